// ### common/uart_ctrl_pkg.sv
package uart_ctrl_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int          REG_ADDR_W   = 4;
  localparam logic [3:0]  OFF_DATA     = 4'h0;
  localparam logic [3:0]  OFF_IID_FCR  = 4'h2;
  localparam logic [3:0]  OFF_LINE     = 4'h5;
  localparam logic [3:0]  OFF_DIV_LO   = 4'h8;
  localparam logic [3:0]  OFF_DIV_HI   = 4'h9;
  localparam logic [15:0] DIV_RESET    = 16'h0001;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int FCR_FIFO_EN    = 0;
  localparam int FCR_RX_FLUSH   = 1;
  localparam int FCR_TX_FLUSH   = 2;
  localparam int FCR_DMA_SEL    = 3;
  localparam int FCR_TRIG_LO    = 6;
  localparam int EN_RX_DATA     = 0;
  localparam int EN_TX_EMPTY    = 1;
  localparam int EN_LINE        = 2;
  localparam int EN_MODEM       = 3;

  // ************************************************************
  // Identification codes and trigger levels
  // ************************************************************
  localparam logic [3:0] IID_NONE    = 4'h1;
  localparam logic [3:0] IID_LINE    = 4'h6;
  localparam logic [3:0] IID_RX_DATA = 4'h4;
  localparam logic [3:0] IID_TIMEOUT = 4'hC;
  localparam logic [3:0] IID_TX_EMPT = 4'h2;
  localparam logic [3:0] IID_MODEM   = 4'h0;
  localparam logic [1:0] IID_RSVD    = 2'h0;
  localparam logic [4:0] TRIG_LEVEL [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
  localparam int         TIMEOUT_CHARS   = 4;
  localparam int         BAUD_OVERSAMPLE = 16;
  localparam int         CHAR_BITS       = 10;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [REG_ADDR_W-1:0] addr;
    logic [7:0]            wdata;
    logic                  wr;
    logic                  rd;
  } reg_req_t;

  typedef struct packed {
    logic       brk;
    logic       framing;
    logic       parity;
    logic [7:0] data;
  } rx_entry_t;

endpackage : uart_ctrl_pkg

// ### core/fifo_mem.sv
`timescale 1ns/10ps
module fifo_mem import uart_ctrl_pkg::*; #(
  parameter int WIDTH  = 8,
  parameter int ADDR_W = 4
) (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [WIDTH-1:0]  wdata,
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [WIDTH-1:0]  rdata
);

  logic [WIDTH-1:0] mem [2**ADDR_W];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Bypass so a push into an empty queue shows at the head at once
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata <= '0;
    end else if (we && waddr == raddr) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule : fifo_mem

// ### core/baud_gen.sv
`timescale 1ns/10ps
module baud_gen import uart_ctrl_pkg::*; (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        load_lo,
  input  wire logic        load_hi,
  input  wire logic [7:0]  wdata,
  output logic      [15:0] divisor,
  output logic             baud_tick
);

  logic [15:0] count;
  logic [15:0] next_divisor;
  logic        load;

  assign load         = load_lo || load_hi;
  assign next_divisor = load_lo ? {divisor[15:8], wdata} :
                        load_hi ? {wdata, divisor[7:0]} : divisor;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      divisor <= DIV_RESET;
    end else begin
      divisor <= next_divisor;
    end
  end

  // Zero divisor behaves as one: a tick every cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count     <= DIV_RESET;
      baud_tick <= 1'b0;
    end else if (load) begin
      count     <= next_divisor; // [R7]
      baud_tick <= 1'b0;
    end else if (count <= 16'h0001) begin
      count     <= divisor; // [R6]
      baud_tick <= 1'b1;
    end else begin
      count     <= count - 16'h0001;
      baud_tick <= 1'b0;
    end
  end

  counter_reload_a: assert property (@(posedge ref_clk) disable iff (reset)
    load |=> count == $past(next_divisor)) else $error("baud counter not reloaded"); // [R7]
  tick_spacing_a: assert property (@(posedge ref_clk) disable iff (reset)
    (baud_tick && divisor > 16'h0001 && !load) |-> ##1 !baud_tick) else $error("baud ticks too close"); // [R6]

endmodule : baud_gen

// ### core/uart_status_fifo_baud_ctrl.sv
// Functional notes
// [R1] Line status source has top priority, code 0110, cleared by line status read.
// [R2] Received data at second priority, code 0100, cleared by reads or below trigger.
// [R3] FIFO mode timeout code 1100 after four idle char times with data held.
// [R4] Holding empty at third priority, code 0010, cleared by identification read or write.
// [R5] Modem status code 0000 lowest; nothing pending reads bit 0 as one.
// [R6] Sixteen-bit divisor in two bytes; tick rate is clock over divisor.
// [R7] Baud counter reloads at once when either divisor byte is written.
// [R8] Host loads divisor at start and avoids divisor zero.
// [R9] Data ready set on character arrival, cleared when all data read.
// [R10] Overrun set when unread character is lost, cleared by line status read.
// [R11] FIFO full overrun flagged at once; new character is not stored.
// [R12] Parity error kept per character, shown at head, cleared by status read.
// [R13] Framing error kept per character, shown at head, cleared by status read.
// [R14] After framing error the receiver resynchronises on the low level.
// [R15] Break flagged; one zero character stored until line marks again.
// [R16] Holding empty set when holding register or FIFO empty, cleared on write.
// [R17] Transmitter empty only while holding stage and shift register both empty.
// [R18] Error summary bit zero outside FIFO mode, else any error in FIFO.
// [R19] Write-only FIFO control at identification offset; bit 0 gates other bits.
// [R20] Flush bits empty one FIFO and zero its counters; they self clear.
// [R21] DMA select bit moves request pins to mode 1 with FIFOs on.
// [R22] Trigger select bits 7:6 give 1, 4, 8 or 14 bytes.
// [R23] Identification bits 5:4 read zero, bits 7:6 one in FIFO mode.
// [R24] Sixteen-entry FIFOs each way, receive entries carry error flags.
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
module uart_status_fifo_baud_ctrl import uart_ctrl_pkg::*; #(
  parameter int FIFO_DEPTH_LOG2 = 4,
  parameter int CHAR_TICKS      = BAUD_OVERSAMPLE * CHAR_BITS
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire reg_req_t   host_req,
  output logic      [7:0] host_rdata,
  input  wire rx_entry_t  rx_char,
  input  wire logic       rx_char_valid,
  input  wire logic       serial_input_pin,
  output logic      [7:0] tx_char,
  output logic            tx_char_valid,
  input  wire logic       tx_char_take,
  input  wire logic       tx_shift_busy,
  input  wire logic [3:0] int_enable,
  input  wire logic       modem_status_pending,
  output logic            int_pending,
  output logic            baud_tick,
  output logic            rx_dma_request_pin_n,
  output logic            tx_dma_request_pin_n
);

  // ************************************************************
  // Parameter checks and local sizes
  // ************************************************************
  localparam int PTR_W = FIFO_DEPTH_LOG2;
  localparam int CNT_W = FIFO_DEPTH_LOG2 + 1;
  localparam logic [CNT_W-1:0] DEPTH    = CNT_W'(2 ** FIFO_DEPTH_LOG2);
  localparam logic [CNT_W-1:0] ONE_CHAR = CNT_W'(1);
  localparam logic [15:0]      TO_LIMIT = 16'(TIMEOUT_CHARS * CHAR_TICKS);

  // Trigger level of 14 needs at least 16 entries
  if (FIFO_DEPTH_LOG2 < 4 || FIFO_DEPTH_LOG2 > 8) begin : bad_depth
    $error("FIFO_DEPTH_LOG2 out of range");
  end
  if (CHAR_TICKS < 1 || TIMEOUT_CHARS * CHAR_TICKS > 65535) begin : bad_ticks
    $error("CHAR_TICKS out of range");
  end

  // ************************************************************
  // Address decode
  // ************************************************************
  logic wr_data, rd_data, wr_fcr, rd_iid, rd_line, wr_div_lo, wr_div_hi, rd_div_lo, rd_div_hi;

  always_comb begin
    wr_data   = 1'b0;
    rd_data   = 1'b0;
    wr_fcr    = 1'b0;
    rd_iid    = 1'b0;
    rd_line   = 1'b0;
    wr_div_lo = 1'b0;
    wr_div_hi = 1'b0;
    rd_div_lo = 1'b0;
    rd_div_hi = 1'b0;
    if (host_req.addr == OFF_DATA) begin
      wr_data = host_req.wr;
      rd_data = host_req.rd;
    end else if (host_req.addr == OFF_IID_FCR) begin
      wr_fcr = host_req.wr; // [R19]
      rd_iid = host_req.rd;
    end else if (host_req.addr == OFF_LINE) begin
      rd_line = host_req.rd;
    end else if (host_req.addr == OFF_DIV_LO) begin
      wr_div_lo = host_req.wr;
      rd_div_lo = host_req.rd;
    end else if (host_req.addr == OFF_DIV_HI) begin
      wr_div_hi = host_req.wr;
      rd_div_hi = host_req.rd;
    end
  end

  // ************************************************************
  // FIFO control
  // ************************************************************
  logic       fifo_en, dma_mode;
  logic [1:0] trig_sel;
  logic       mode_change, rx_flush, tx_flush;

  assign mode_change = wr_fcr && (host_req.wdata[FCR_FIFO_EN] != fifo_en);
  assign rx_flush    = mode_change || (wr_fcr && host_req.wdata[FCR_FIFO_EN] && host_req.wdata[FCR_RX_FLUSH]); // [R20]
  assign tx_flush    = mode_change || (wr_fcr && host_req.wdata[FCR_FIFO_EN] && host_req.wdata[FCR_TX_FLUSH]); // [R20]

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fifo_en  <= 1'b0;
      dma_mode <= 1'b0;
      trig_sel <= 2'h0;
    end else if (wr_fcr) begin
      fifo_en <= host_req.wdata[FCR_FIFO_EN]; // [R19]
      if (host_req.wdata[FCR_FIFO_EN]) begin
        dma_mode <= host_req.wdata[FCR_DMA_SEL]; // [R21]
        trig_sel <= host_req.wdata[FCR_TRIG_LO +: 2]; // [R22]
      end
    end
  end

  // ************************************************************
  // Receive queue
  // ************************************************************
  // Outside FIFO mode the queue is one deep and acts as the buffer register
  logic [CNT_W-1:0] rx_count, cap;
  logic [PTR_W-1:0] rx_wr_ptr, rx_rd_ptr, next_rx_rd_ptr, rx_waddr;
  logic             rx_full, rx_accept, rx_push, rx_pop, rx_overwrite, rx_overrun, rx_we;
  logic             break_hold, head_new;
  rx_entry_t        rx_head;
  logic [2**PTR_W-1:0] err_slot;

  assign cap          = fifo_en ? DEPTH : ONE_CHAR;
  assign rx_pop       = rd_data && rx_count != '0;
  assign rx_full      = rx_count >= cap && !rx_pop;
  assign rx_accept    = rx_char_valid && !break_hold; // [R15]
  assign rx_push      = rx_accept && !rx_full && !rx_flush;
  assign rx_overrun   = rx_accept && rx_full && !rx_flush;
  assign rx_overwrite = rx_overrun && !fifo_en; // [R10]
  assign rx_we        = rx_push || rx_overwrite; // [R11]
  assign rx_waddr     = rx_overwrite ? rx_rd_ptr : rx_wr_ptr;
  assign next_rx_rd_ptr = rx_flush ? '0 : rx_rd_ptr + PTR_W'(rx_pop);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx_wr_ptr <= '0;
      rx_rd_ptr <= '0;
      rx_count  <= '0;
    end else begin
      rx_rd_ptr <= next_rx_rd_ptr;
      if (rx_flush) begin
        rx_wr_ptr <= '0; // [R20]
        rx_count  <= '0;
      end else begin
        rx_wr_ptr <= rx_wr_ptr + PTR_W'(rx_push);
        rx_count  <= rx_count + CNT_W'(rx_push) - CNT_W'(rx_pop); // [R9]
      end
    end
  end

  fifo_mem #(
    .WIDTH  ($bits(rx_entry_t)),
    .ADDR_W (PTR_W)
  ) rx_mem ( // [R24]
    .ref_clk (ref_clk),
    .reset   (reset),
    .we      (rx_we),
    .waddr   (rx_waddr),
    .wdata   (rx_char),
    .raddr   (next_rx_rd_ptr),
    .rdata   (rx_head)
  );

  // Framing errors do not block the next character, so resync runs freely
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      break_hold <= 1'b0;
    end else begin
      break_hold <= (rx_push && rx_char.brk) || (break_hold && !serial_input_pin); // [R15] [R14]
    end
  end

  // Head flags are checked the cycle after the head changes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      head_new <= 1'b0;
    end else begin
      // A push beside the pop of the last character also lands at the head
      head_new <= (rx_push && rx_count == CNT_W'(rx_pop)) || (rx_pop && rx_count > ONE_CHAR)
                  || rx_overwrite; // [R12] [R13]
    end
  end

  for (genvar i = 0; i < 2 ** PTR_W; i++) begin : g_err_slot
    always_ff @(posedge ref_clk) begin
      if (reset || rx_flush) begin
        err_slot[i] <= 1'b0;
      end else if (rx_we && rx_waddr == PTR_W'(i)) begin
        err_slot[i] <= rx_char.brk || rx_char.framing || rx_char.parity; // [R18]
      end else if (rx_pop && rx_rd_ptr == PTR_W'(i)) begin
        err_slot[i] <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Line status
  // ************************************************************
  logic       lsr_overrun;
  logic [2:0] lsr_err;
  logic       err_summary, tx_holding_empty_flag, tx_all_empty_flag, line_pending, rx_data_ready_flag;
  logic [7:0] line_status;

  // A new event in the read cycle survives the clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lsr_overrun <= 1'b0;
      lsr_err     <= 3'h0;
    end else begin
      lsr_overrun <= rx_overrun || (lsr_overrun && !rd_line); // [R10] [R11]
      lsr_err     <= ({rx_head.brk, rx_head.framing, rx_head.parity} & {3{head_new}})
                     | (lsr_err & ~{3{rd_line}}); // [R12] [R13] [R15]
    end
  end

  assign rx_data_ready_flag = rx_count != '0; // [R9]
  assign err_summary  = fifo_en && |err_slot; // [R18]
  assign line_pending = lsr_overrun || |lsr_err; // [R1]
  assign line_status  = {err_summary, tx_all_empty_flag, tx_holding_empty_flag, lsr_err, lsr_overrun, rx_data_ready_flag};

  // ************************************************************
  // Transmit queue
  // ************************************************************
  logic [CNT_W-1:0] tx_count;
  logic [PTR_W-1:0] tx_wr_ptr, tx_rd_ptr, next_tx_rd_ptr;
  logic             tx_push, tx_pop, tx_holding_empty_flag_int;

  // Writes into a full queue are dropped unless a character is taken in the same cycle
  assign tx_pop         = tx_char_take && tx_count != '0;
  assign tx_push        = wr_data && (tx_count < cap || tx_pop) && !tx_flush;
  assign next_tx_rd_ptr = tx_flush ? '0 : tx_rd_ptr + PTR_W'(tx_pop);
  assign tx_char_valid  = tx_count != '0;
  assign tx_holding_empty_flag           = tx_count == '0; // [R16]
  assign tx_all_empty_flag           = tx_holding_empty_flag && !tx_shift_busy; // [R17]

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_wr_ptr <= '0;
      tx_rd_ptr <= '0;
      tx_count  <= '0;
    end else begin
      tx_rd_ptr <= next_tx_rd_ptr;
      if (tx_flush) begin
        tx_wr_ptr <= '0; // [R20]
        tx_count  <= '0;
      end else begin
        tx_wr_ptr <= tx_wr_ptr + PTR_W'(tx_push);
        tx_count  <= tx_count + CNT_W'(tx_push) - CNT_W'(tx_pop); // [R16]
      end
    end
  end

  fifo_mem #(
    .WIDTH  (8),
    .ADDR_W (PTR_W)
  ) tx_mem ( // [R24]
    .ref_clk (ref_clk),
    .reset   (reset),
    .we      (tx_push),
    .waddr   (tx_wr_ptr),
    .wdata   (host_req.wdata),
    .raddr   (next_tx_rd_ptr),
    .rdata   (tx_char)
  );

  // ************************************************************
  // Receive timeout
  // ************************************************************
  logic [15:0] to_count;
  logic        timeout_hit;

  always_ff @(posedge ref_clk) begin
    if (reset || !fifo_en || rx_count == '0 || rx_push || rx_pop || rx_flush) begin
      to_count <= 16'h0000; // [R3]
    end else if (baud_tick && to_count != TO_LIMIT) begin
      to_count <= to_count + 16'h0001;
    end
  end

  assign timeout_hit = to_count == TO_LIMIT; // [R3]

  // ************************************************************
  // Interrupt identification
  // ************************************************************
  logic [3:0] iid_code;
  logic       rda_level;

  assign rda_level = fifo_en ? rx_count >= CNT_W'(TRIG_LEVEL[trig_sel]) : rx_data_ready_flag; // [R2] [R22]

  always_comb begin
    if (int_enable[EN_LINE] && line_pending) begin
      iid_code = IID_LINE; // [R1]
    end else if (int_enable[EN_RX_DATA] && rda_level) begin
      iid_code = IID_RX_DATA; // [R2]
    end else if (int_enable[EN_RX_DATA] && timeout_hit) begin
      iid_code = IID_TIMEOUT; // [R3]
    end else if (int_enable[EN_TX_EMPTY] && tx_holding_empty_flag_int) begin
      iid_code = IID_TX_EMPT; // [R4]
    end else if (int_enable[EN_MODEM] && modem_status_pending) begin
      iid_code = IID_MODEM; // [R5]
    end else begin
      iid_code = IID_NONE; // [R5]
    end
  end

  assign int_pending = !iid_code[0];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tx_holding_empty_flag_int <= 1'b1;
    end else begin
      tx_holding_empty_flag_int <= (tx_pop && tx_count == ONE_CHAR && !tx_push) || tx_flush
                  || (tx_holding_empty_flag_int && !tx_push && !(rd_iid && iid_code == IID_TX_EMPT)); // [R4]
    end
  end

  // ************************************************************
  // DMA request pins
  // ************************************************************
  logic dma_mode1;

  assign dma_mode1            = fifo_en && dma_mode; // [R21]
  assign rx_dma_request_pin_n = !(dma_mode1 ? (rda_level || timeout_hit) : rx_data_ready_flag);
  assign tx_dma_request_pin_n = !(dma_mode1 ? tx_count < cap : tx_holding_empty_flag);

  // ************************************************************
  // Baud generator and read data
  // ************************************************************
  logic [15:0] divisor;

  baud_gen baud ( // [R6]
    .ref_clk   (ref_clk),
    .reset     (reset),
    .load_lo   (wr_div_lo),
    .load_hi   (wr_div_hi),
    .wdata     (host_req.wdata),
    .divisor   (divisor),
    .baud_tick (baud_tick)
  );

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      host_rdata <= 8'h00;
    end else if (rd_data) begin
      host_rdata <= rx_head.data;
    end else if (rd_iid) begin
      host_rdata <= {fifo_en, fifo_en, IID_RSVD, iid_code}; // [R23]
    end else if (rd_line) begin
      host_rdata <= line_status;
    end else if (rd_div_lo) begin
      host_rdata <= divisor[7:0];
    end else if (rd_div_hi) begin
      host_rdata <= divisor[15:8];
    end else begin
      host_rdata <= 8'h00;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_line_read;
    rd_line && !rx_overrun;
  endsequence
  sequence s_iid_read_line;
    rd_iid && int_enable[EN_LINE] && line_pending;
  endsequence

  line_priority_a: assert property (s_iid_read_line |=> host_rdata[3:0] == IID_LINE) // [R1]
    else $error("line status not at top priority");
  rx_data_code_a: assert property (rd_iid && !line_pending && int_enable[EN_RX_DATA] && rda_level
    |=> host_rdata[3:0] == IID_RX_DATA) else $error("received data code wrong"); // [R2]
  timeout_clear_a: assert property (rx_pop |=> !timeout_hit) else $error("timeout survived read"); // [R3]
  tx_holding_empty_flag_clear_a: assert property (tx_push |=> !tx_holding_empty_flag_int) else $error("holding empty not cleared"); // [R4]
  idle_code_a: assert property (rd_iid && !int_pending |=> host_rdata[0]) else $error("idle bit 0 low"); // [R5]
  overrun_clear_a: assert property (s_line_read ##1 !rx_overrun |-> !lsr_overrun) // [R10]
    else $error("overrun not cleared by read");
  overrun_full_a: assert property (rx_overrun && fifo_en |=> lsr_overrun && $stable(rx_count)) // [R11]
    else $error("full fifo overrun wrong");
  data_ready_a: assert property (rx_push |=> rx_data_ready_flag) else $error("data ready not set"); // [R9]
  flush_empty_a: assert property (rx_flush || tx_flush |=> (rx_count == '0 || !$past(rx_flush))
    && (tx_count == '0 || !$past(tx_flush))) else $error("flush left data"); // [R20]
  summary_off_a: assert property (!fifo_en |-> !line_status[7]) else $error("summary set in plain mode"); // [R18]
  iid_upper_a: assert property (rd_iid |=> host_rdata[5:4] == IID_RSVD
    && host_rdata[7:6] == {2{$past(fifo_en)}}) else $error("identification upper bits wrong"); // [R23]

endmodule : uart_status_fifo_baud_ctrl

// ### tb/tx_engine_model.sv
`timescale 1ns/10ps
// ************
// Transmit engine model
// ************
module tx_engine_model #(
  parameter int HOLD = 8
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       stall,
  input  wire logic       tx_char_valid,
  input  wire logic [7:0] tx_char,
  output logic            tx_char_take,
  output logic            tx_shift_busy
);
  int cnt;
  // Stall keeps the holding stage full so its flags can be seen
  always_ff @(posedge ref_clk) begin
    tx_char_take <= 1'b0;
    if (reset) begin
      cnt           <= 0;
      tx_shift_busy <= 1'b0;
    end else if (cnt != 0) begin
      cnt           <= cnt - 1;
      tx_shift_busy <= (cnt > 1);
    end else if (tx_char_valid && !stall && !tx_char_take) begin
      tx_char_take  <= 1'b1;
      tx_shift_busy <= 1'b1;
      cnt           <= HOLD;
    end
  end
endmodule : tx_engine_model

// ### tb/uart_status_fifo_baud_ctrl_tb.sv
`timescale 1ns/10ps
module uart_status_fifo_baud_ctrl_tb import uart_ctrl_pkg::*;;
  logic       ref_clk = 1'b0;
  logic       reset = 1'b1;
  reg_req_t   host_req = '0;
  rx_entry_t  rx_char = '0;
  logic       rx_char_valid = 1'b0;
  logic [3:0] int_enable = 4'h0;
  logic       stall = 1'b0;
  logic       serial_in = 1'b1;
  logic       modem_pend = 1'b0;
  logic [7:0] host_rdata, tx_char;
  logic       tx_char_valid, tx_char_take, tx_shift_busy, int_pending, baud_tick, rx_dma_n, tx_dma_n;
  int         err_total = 0;
  int         tests_run = 0;
  always #50 ref_clk = ~ref_clk;
  uart_status_fifo_baud_ctrl #(.CHAR_TICKS(2)) dut (.ref_clk(ref_clk), .reset(reset), .host_req(host_req),
    .host_rdata(host_rdata), .rx_char(rx_char), .rx_char_valid(rx_char_valid), .serial_input_pin(serial_in),
    .tx_char(tx_char), .tx_char_valid(tx_char_valid), .tx_char_take(tx_char_take),
    .tx_shift_busy(tx_shift_busy), .int_enable(int_enable), .modem_status_pending(modem_pend),
    .int_pending(int_pending), .baud_tick(baud_tick), .rx_dma_request_pin_n(rx_dma_n),
    .tx_dma_request_pin_n(tx_dma_n));
  tx_engine_model partner (.ref_clk(ref_clk), .reset(reset), .stall(stall), .tx_char_valid(tx_char_valid),
    .tx_char(tx_char), .tx_char_take(tx_char_take), .tx_shift_busy(tx_shift_busy));
  // ************
  // Bus and check tasks
  // ************
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    host_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    host_req <= '0;
  endtask : wr
  // Read data exist only in the cycle after the strobe
  task automatic rd(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    host_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    host_req <= '0;
    #1;
    chk(n, e, host_rdata);
  endtask : rd
  task automatic push(input rx_entry_t c);
    @(posedge ref_clk);
    rx_char       <= c;
    rx_char_valid <= 1'b1;
    @(posedge ref_clk);
    rx_char_valid <= 1'b0;
  endtask : push
  task automatic drive(input logic [3:0] ie, input logic st);
    @(posedge ref_clk);
    int_enable <= ie;
    stall      <= st;
  endtask : drive
  task automatic wait_idle();
    int n;
    n = 0;
    while ((tx_char_valid !== 1'b0 || tx_shift_busy !== 1'b0) && n < 50) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (tx_char_valid !== 1'b0 || tx_shift_busy !== 1'b0) begin
      err_total++;
      give_verdict();
    end
  endtask : wait_idle
  task automatic tick_gap(input logic [7:0] e);
    int n;
    repeat (2) begin
      n = 0;
      do begin
        @(posedge ref_clk);
        #1;
        n++;
      end while (baud_tick !== 1'b1 && n < 50);
    end
    chk("tick gap", e, n[7:0]);
    if (n == 50) begin
      give_verdict();
    end
  endtask : tick_gap
  // ************
  // Scenarios
  // ************
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    rd("line", OFF_LINE, 8'h60);
    rd("iid", OFF_IID_FCR, 8'h01);
    drive(4'h2, 1'b1);
    rd("iid", OFF_IID_FCR, 8'h02);
    rd("iid", OFF_IID_FCR, 8'h01);
    chk("int pend", 8'h00, {7'h00, int_pending});
    wr(OFF_DATA, 8'hA5);
    rd("line", OFF_LINE, 8'h00);
    chk("tx char", 8'hA5, tx_char);
    chk("tx dma", 8'h01, {7'h00, tx_dma_n});
    drive(4'h2, 1'b0);
    wait_idle();
    rd("line", OFF_LINE, 8'h60);
    rd("iid", OFF_IID_FCR, 8'h02);
    wr(OFF_DIV_LO, 8'h03);
    rd("div lo", OFF_DIV_LO, 8'h03);
    rd("div hi", OFF_DIV_HI, 8'h00);
    tick_gap(8'h03);
    wr(OFF_DIV_LO, 8'h01);
    drive(4'h5, 1'b0);
    wr(OFF_IID_FCR, 8'h49);
    for (int i = 0; i < 3; i++) begin
      push(11'(16 + i));
    end
    rd("iid", OFF_IID_FCR, 8'hC1);
    chk("rx dma", 8'h01, {7'h00, rx_dma_n});
    chk("tx dma", 8'h00, {7'h00, tx_dma_n});
    push(11'h013);
    rd("iid", OFF_IID_FCR, 8'hC4);
    chk("rx dma", 8'h00, {7'h00, rx_dma_n});
    rd("rx data", OFF_DATA, 8'h10);
    rd("iid", OFF_IID_FCR, 8'hC1);
    repeat (20) @(posedge ref_clk);
    rd("iid", OFF_IID_FCR, 8'hCC);
    rd("rx data", OFF_DATA, 8'h11);
    rd("iid", OFF_IID_FCR, 8'hC1);
    push(11'h155);
    rd("line", OFF_LINE, 8'hE1);
    rd("rx data", OFF_DATA, 8'h12);
    rd("rx data", OFF_DATA, 8'h13);
    rd("iid", OFF_IID_FCR, 8'hC6);
    chk("int pend", 8'h01, {7'h00, int_pending});
    rd("line", OFF_LINE, 8'hE5);
    rd("rx data", OFF_DATA, 8'h55);
    rd("line", OFF_LINE, 8'h60);
    for (int i = 0; i < 17; i++) begin
      push(11'(i));
    end
    rd("line", OFF_LINE, 8'h63);
    for (int i = 0; i < 16; i++) begin
      rd("rx data", OFF_DATA, 8'(i));
    end
    rd("line", OFF_LINE, 8'h60);
    push(11'h0AA);
    wr(OFF_IID_FCR, 8'h43);
    rd("line", OFF_LINE, 8'h60);
    wr(OFF_IID_FCR, 8'hC0);
    rd("iid", OFF_IID_FCR, 8'h01);
    give_verdict();
  end
endmodule : uart_status_fifo_baud_ctrl_tb
